// file: rtl/tbc_regs.svh
// Register offsets, field positions, codes and timing counts of the transmit beamformer control.
`ifndef TBC_REGS_SVH
`define TBC_REGS_SVH

`define TBC_NUM_REGS        28
`define TBC_NUM_SHORT_REGS  9
`define TBC_MEM_DEPTH       128
`define TBC_NUM_CH          16
`define TBC_CHDL_BITS       144

`define TBC_REG_FIRST_ADDR  5'h00
`define TBC_REG_LAST_ADDR   5'h01
`define TBC_REG_PAT_CTRL    5'h02
`define TBC_REG_REPEAT      5'h03
`define TBC_REG_SUPPLY_TRIM 5'h04
`define TBC_REG_TXM_HI      5'h05
`define TBC_REG_TXM_LO      5'h06
`define TBC_REG_RXM_HI      5'h07
`define TBC_REG_RXM_LO      5'h08
`define TBC_REG_COM_DELAY   5'h09
`define TBC_REG_CHDL_FIRST  5'h0a
`define TBC_REG_RESET_VAL   8'h00

`define TBC_BIT_POL_SWAP    7
`define TBC_BIT_REP_SCALE   6
`define TBC_BIT_DRIVE_SEL   4
`define TBC_POS_DIV         2
`define TBC_POS_OVERTEMP    0

`define TBC_CMD_WRITE       2'h0
`define TBC_CMD_READ        2'h1
`define TBC_CMD_ERR         2'h2
`define TBC_CMD_COMPUTED_CHECK_VALUE        2'h3
`define TBC_SEL_SHORT       2'h0
`define TBC_SEL_ALL         2'h1
`define TBC_SEL_NONE        2'h2
`define TBC_SEL_MEM         2'h3

`define TBC_CRC_POLY        8'h31
`define TBC_CRC_INIT        8'h00

`define TBC_LVL_GND         2'h0
`define TBC_LVL_POS         2'h1
`define TBC_LVL_NEG         2'h2

`define TBC_REP_ONCE        8'h00
`define TBC_REP_CONT        8'hff
`define TBC_REP_MULT        12'd16

`define TBC_THR_110         8'h6e
`define TBC_THR_130         8'h82
`define TBC_THR_150         8'h96
`define TBC_OT_NO_RESET     2'h3

`define TBC_WIDTH_EXTRA     9'd2
`define TBC_COM_STEP_HALF   16'd32
`define TBC_COM_BASE_HALF   16'd36
`define TBC_COM_FIX_HALF    16'd4

`define TBC_ERR_CRC         0
`define TBC_ERR_ADDR        1
`define TBC_ERR_TEMP        2

`endif

// file: rtl/tbc_pkg.sv
// Types shared by the transmit beamformer control.
package tbc_pkg;

   typedef enum logic [2:0] {
      SER_IDLE,
      SER_HDR,
      SER_WDATA,
      SER_WCRC,
      SER_RDATA,
      SER_END
   } tbc_ser_t;

   typedef logic [27:0][7:0] tbc_regs_t;

   typedef struct packed {
      logic        started;
      logic        play;
      logic [6:0]  addr;
      logic [8:0]  wcnt;
      logic [11:0] rep;
   } tbc_chan_t;

   typedef struct packed {
      tbc_ser_t         ser;
      logic [2:0]       bitcnt;
      logic [7:0]       shin;
      logic [7:0]       shout;
      logic [7:0]       idx;
      logic [7:0]       nbytes;
      logic [7:0]       hdr;
      logic [7:0]       crc_calc;
      logic [7:0]       crc_rx;
      logic [7:0]       computed_check_value;
      logic [7:0]       err;
      logic             sclk_prev;
      logic             fire_prev;
      logic             dis_prev;
      logic             sdo;
      logic             fault;
      logic             run;
      logic [15:0]      t;
      tbc_regs_t        regs;
      tbc_chan_t [15:0] ch;
      logic [15:0]      hvp;
      logic [15:0]      hvn;
      logic [15:0]      rxsw;
   } tbc_state_t;

endpackage

// file: rtl/tbc_top.sv
// Serial control, waveform memory, delay and pattern generation of the transmit beamformer.
`timescale 1ns/1ps
`include "tbc_regs.svh"

// Function
// - Header bits 5:4 at 00 write 9 regs, 28 regs or memory, then a check byte.
// - Header bits 5:4 at 01 read 9 regs, 28 regs or memory, then stored check byte.
// - Header 10 returns the error flags, header 11 returns the computed check value.
// - Check code is polynomial x8+x5+x4+1 starting from zero.
// - Writes store the computed check, flag a mismatch in error bit 0 and on fault.
// - Reads ignore serial input after the header and skip checking.
// - Read trailer is the check byte received in the latest write.
// - Transmission starts at the fire falling edge, each channel after its delay.
// - Receive switch is on for masked channels except during burst or disable.
// - Level code 00 ground, 01 positive, 10 negative, swapped by polarity bit.
// - Pattern plays entries first to last address; code high, length low.
// - Pulse lasts divide factor times half periods times length plus two.
// - Divider field 00 gives 1, 01 gives 2, 10 and 11 give 4.
// - Channel start is common delay plus channel delay, half period resolution.
// - Common delay is 160ns times field plus 200ns when undivided.
// - Channel delay is divide factor times half periods times 9-bit field.
// - Select or fire going high stops pulsing and resets transmission.
// - Enabled with select high: access allowed, transmit reset, reception kept.
// - Overtemperature code picks 110, 130, 150 degC; code 11 skips transmit reset.
// - Disabled with select high: memory access and register reads, no reg writes.
// - Error bit 1 on equal pattern addresses, bit 2 on overtemperature.
// - Error flags clear at reset and on disable pin falling edge.
// - Repeat zero plays once, all ones forever, else value times one or 16.
module tbc_top
   import tbc_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        chip_disable,
   input  wire logic        select_line_pos,
   input  wire logic        serial_clock,
   input  wire logic        serial_input_pin,
   input  wire logic        serial_receiver_power,
   input  wire logic        fire_input,
   input  wire logic [7:0]  junction_temp,
   output logic             serial_output_pin,
   output logic             fault_out,
   output logic             fault_oe_n,
   output logic [15:0]      hv_pos,
   output logic [15:0]      hv_neg,
   output logic [15:0]      rx_protect_switch
);

   // Each clk cycle stands for one half period of the undivided timebase, so all
   // counts below are in half periods and the divide factor multiplies them.

   // The check code is shifted in one bit at a time, most significant bit first.
   // That keeps the bit order identical to the host's without a lookup table.
   function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
      logic [7:0] r;
      r = c;
      for (int k = 7; k >= 0; k--) begin
         if (r[7] ^ b[k]) begin
            r = {r[6:0], 1'b0} ^ `TBC_CRC_POLY;
         end else begin
            r = {r[6:0], 1'b0};
         end
      end
      return r;
   endfunction

   // Divider codes 10 and 11 both select four.
   function automatic logic [2:0] ndiv(input logic [1:0] f);
      logic [2:0] n;
      n = 3'd4;
      if (f == 2'h0) begin
         n = 3'd1;
      end else if (f == 2'h1) begin
         n = 3'd2;
      end
      return n;
   endfunction

   function automatic logic [8:0] wlen(input logic [2:0] n, input logic [5:0] w);
      return 9'(n) * (9'(w) + `TBC_WIDTH_EXTRA);
   endfunction

   function automatic logic [7:0] sel_len(input logic [1:0] s);
      logic [7:0] n;
      n = 8'h00;
      if (s == `TBC_SEL_SHORT) begin
         n = 8'(`TBC_NUM_SHORT_REGS);
      end else if (s == `TBC_SEL_ALL) begin
         n = 8'(`TBC_NUM_REGS);
      end else if (s == `TBC_SEL_MEM) begin
         n = 8'(`TBC_MEM_DEPTH);
      end
      return n;
   endfunction

   // Delay fields straddle byte boundaries, so the bytes are laid end to end
   // in one vector first and each 9-bit field is then cut out of it.
   function automatic logic [8:0] chan_delay(input tbc_regs_t r, input int i);
      logic [`TBC_CHDL_BITS-1:0] v;
      v = '0;
      for (int k = 0; k < `TBC_NUM_REGS - 10; k++) begin
         v[`TBC_CHDL_BITS-1-8*k -: 8] = r[10+k];
      end
      return v[`TBC_CHDL_BITS-1-9*i -: 9];
   endfunction

   // Code 11 keeps the middle threshold so that the fault flag still reports.
   function automatic logic [7:0] temp_thr(input logic [1:0] c);
      logic [7:0] t;
      t = `TBC_THR_130;
      if (c == 2'h0) begin
         t = `TBC_THR_110;
      end else if (c == 2'h2) begin
         t = `TBC_THR_150;
      end
      return t;
   endfunction

   logic [7:0]  mem [0:`TBC_MEM_DEPTH-1];
   tbc_state_t  q;
   tbc_state_t  d;
   logic        mem_we;
   logic [6:0]  mem_wa;
   logic [7:0]  mem_wd;
   logic [7:0]  nb;
   logic [7:0]  nxt;
   logic [7:0]  e;
   logic [7:0]  ctrl;
   logic [2:0]  nd;
   logic [15:0] txm;
   logic [15:0] rxm;
   logic [6:0]  first_a;
   logic [6:0]  last_a;
   logic [15:0] com_dly;
   logic [15:0] start_t;
   logic [11:0] reps;
   logic [1:0]  code;
   logic        frame;
   logic        rise;
   logic        crc_bad;
   logic        crc_ok;
   logic        trip;
   logic        tx_rst;
   logic        fire_fall;
   logic        cont;

   always_comb begin
      d         = q;
      mem_we    = 1'b0;
      mem_wa    = 7'h00;
      mem_wd    = 8'h00;
      nb        = {q.shin[6:0], serial_input_pin};
      nxt       = 8'h00;
      crc_bad   = 1'b0;
      crc_ok    = 1'b0;
      ctrl      = q.regs[`TBC_REG_PAT_CTRL];
      nd        = ndiv(ctrl[`TBC_POS_DIV +: 2]);
      txm       = {q.regs[`TBC_REG_TXM_HI], q.regs[`TBC_REG_TXM_LO]};
      rxm       = {q.regs[`TBC_REG_RXM_HI], q.regs[`TBC_REG_RXM_LO]};
      first_a   = q.regs[`TBC_REG_FIRST_ADDR][6:0];
      last_a    = q.regs[`TBC_REG_LAST_ADDR][6:0];
      frame     = select_line_pos & serial_receiver_power;
      rise      = serial_clock & ~q.sclk_prev;
      d.sclk_prev = serial_clock;
      d.fire_prev = fire_input;
      d.dis_prev  = chip_disable;

      // Serial engine; leaving select low aborts any frame in progress.
      // Bytes of a cut write that were already stored are kept.
      if (!frame) begin
         d.ser = SER_IDLE;
      end else if (q.ser == SER_IDLE) begin
         d.ser    = SER_HDR;
         d.bitcnt = 3'h0;
      end else if (rise) begin
         d.shin   = nb;
         d.bitcnt = q.bitcnt + 3'h1;
         d.shout  = {q.shout[6:0], 1'b0};
         if (q.bitcnt == 3'h7) begin
            unique case (q.ser)
               SER_HDR: begin
                  d.hdr      = nb;
                  d.idx      = 8'h00;
                  d.crc_calc = `TBC_CRC_INIT;
                  d.nbytes   = sel_len(nb[7:6]);
                  unique case (nb[5:4])
                     `TBC_CMD_WRITE: begin
                        d.ser = (d.nbytes == 8'h00) ? SER_END : SER_WDATA;
                     end
                     `TBC_CMD_READ: begin
                        d.ser = (d.nbytes == 8'h00) ? SER_END : SER_RDATA;
                        if (nb[7:6] == `TBC_SEL_MEM) begin
                           d.shout = mem[0];
                        end else begin
                           d.shout = q.regs[0];
                        end
                     end
                     `TBC_CMD_ERR: begin
                        d.ser    = SER_RDATA;
                        d.nbytes = 8'h00;
                        d.shout  = q.err;
                     end
                     `TBC_CMD_COMPUTED_CHECK_VALUE: begin
                        d.ser    = SER_RDATA;
                        d.nbytes = 8'h00;
                        d.shout  = q.computed_check_value;
                     end
                  endcase
               end
               SER_WDATA: begin
                  d.crc_calc = crc8(q.crc_calc, nb);
                  d.idx      = q.idx + 8'h01;
                  if (q.hdr[7:6] == `TBC_SEL_MEM) begin
                     mem_we = 1'b1;
                     mem_wa = q.idx[6:0];
                     mem_wd = nb;
                  end else if (!chip_disable) begin
                     d.regs[q.idx[4:0]] = nb;
                  end
                  if (d.idx == q.nbytes) begin
                     d.ser = SER_WCRC;
                  end
               end
               SER_WCRC: begin
                  d.crc_rx = nb;
                  d.computed_check_value   = q.crc_calc;
                  crc_bad  = (nb != q.crc_calc);
                  crc_ok   = ~crc_bad;
                  d.ser    = SER_END;
               end
               SER_RDATA: begin
                  // Incoming bits are shifted in but never stored or checked.
                  d.idx = q.idx + 8'h01;
                  if (q.idx >= q.nbytes) begin
                     d.ser = SER_END;
                  end else if (d.idx == q.nbytes) begin
                     d.shout = q.crc_rx;
                  end else begin
                     if (q.hdr[7:6] == `TBC_SEL_MEM) begin
                        nxt = mem[d.idx[6:0]];
                     end else begin
                        nxt = q.regs[d.idx[4:0]];
                     end
                     d.shout = nxt;
                  end
               end
               SER_END: begin
                  d.ser = SER_END;
               end
               default: begin
                  d.ser = SER_IDLE;
               end
            endcase
         end
      end
      d.sdo = (d.ser == SER_RDATA) ? d.shout[7] : 1'b0;

      // Error flags; a set in the same cycle as a clear wins.
      // Bit 1 sets again every cycle while the addresses match, so a clear
      // only sticks once the host has made them differ.
      trip = (junction_temp > temp_thr(ctrl[`TBC_POS_OVERTEMP +: 2]));
      e = q.err;
      if (q.dis_prev && !chip_disable) begin
         e = 8'h00;
      end
      if (crc_ok) begin
         e[`TBC_ERR_CRC] = 1'b0;
      end
      e[`TBC_ERR_CRC]  = e[`TBC_ERR_CRC] | crc_bad;
      e[`TBC_ERR_ADDR] = e[`TBC_ERR_ADDR] | (first_a == last_a);
      e[`TBC_ERR_TEMP] = e[`TBC_ERR_TEMP] | trip;
      d.err   = e;
      d.fault = |e;

      // Transmission control.
      // Any reset condition clears every channel at once; there is no graceful
      // end to a burst, which is what stops a continuous wave promptly.
      // The time counter saturates, so a late channel cannot start twice.
      tx_rst = chip_disable | select_line_pos | fire_input |
               (trip & (ctrl[`TBC_POS_OVERTEMP +: 2] != `TBC_OT_NO_RESET));
      fire_fall = q.fire_prev & ~fire_input;
      com_dly = (16'(q.regs[`TBC_REG_COM_DELAY]) * `TBC_COM_STEP_HALF + `TBC_COM_BASE_HALF)
                * 16'(nd) + `TBC_COM_FIX_HALF;
      cont = (q.regs[`TBC_REG_REPEAT] == `TBC_REP_CONT);
      if (q.regs[`TBC_REG_REPEAT] == `TBC_REP_ONCE) begin
         reps = 12'h000;
      end else if (ctrl[`TBC_BIT_REP_SCALE]) begin
         reps = 12'(q.regs[`TBC_REG_REPEAT]) - 12'h001;
      end else begin
         reps = 12'(q.regs[`TBC_REG_REPEAT]) * `TBC_REP_MULT - 12'h001;
      end
      if (tx_rst) begin
         d.run = 1'b0;
         d.t   = 16'h0000;
         d.ch  = '0;
      end else if (fire_fall) begin
         d.run = 1'b1;
         d.t   = 16'h0000;
         d.ch  = '0;
      end else if (q.run && q.t != 16'hffff) begin
         d.t = q.t + 16'h0001;
      end

      for (int i = 0; i < `TBC_NUM_CH; i++) begin
         start_t = com_dly + 16'(nd) * 16'(chan_delay(q.regs, i));
         if (q.run && !tx_rst && !fire_fall) begin
            if (!q.ch[i].started && txm[i] && q.t == start_t) begin
               d.ch[i].started = 1'b1;
               d.ch[i].play    = 1'b1;
               d.ch[i].addr    = first_a;
               d.ch[i].wcnt    = wlen(nd, mem[first_a][5:0]);
               d.ch[i].rep     = reps;
            end else if (q.ch[i].play) begin
               if (q.ch[i].wcnt <= 9'd1) begin
                  if (q.ch[i].addr == last_a) begin
                     if (cont || q.ch[i].rep != 12'h000) begin
                        d.ch[i].addr = first_a;
                        d.ch[i].wcnt = wlen(nd, mem[first_a][5:0]);
                        if (!cont) begin
                           d.ch[i].rep = q.ch[i].rep - 12'h001;
                        end
                     end else begin
                        d.ch[i].play = 1'b0;
                     end
                  end else begin
                     d.ch[i].addr = q.ch[i].addr + 7'h01;
                     d.ch[i].wcnt = wlen(nd, mem[q.ch[i].addr + 7'h01][5:0]);
                  end
               end else begin
                  d.ch[i].wcnt = q.ch[i].wcnt - 9'd1;
               end
            end
         end
         code = q.ch[i].play ? mem[q.ch[i].addr][7:6] : `TBC_LVL_GND;
         // Code 11 is illegal and is driven as ground clamp.
         d.hvp[i] = ((code == `TBC_LVL_POS) & ~ctrl[`TBC_BIT_POL_SWAP]) |
                    ((code == `TBC_LVL_NEG) & ctrl[`TBC_BIT_POL_SWAP]);
         d.hvn[i] = ((code == `TBC_LVL_NEG) & ~ctrl[`TBC_BIT_POL_SWAP]) |
                    ((code == `TBC_LVL_POS) & ctrl[`TBC_BIT_POL_SWAP]);
         d.rxsw[i] = rxm[i] & ~q.ch[i].play & ~chip_disable;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // The waveform memory has no reset; contents are undefined until written.
   always_ff @(posedge clk) begin
      if (mem_we) begin
         mem[mem_wa] <= mem_wd;
      end
   end

   // The fault pin is open drain: its data stays low and only the enable moves.
   assign serial_output_pin = q.sdo;
   assign fault_out         = 1'b0;
   assign fault_oe_n        = ~q.fault;
   assign hv_pos            = q.hvp;
   assign hv_neg            = q.hvn;
   assign rx_protect_switch = q.rxsw;

endmodule

// file: dv/tbc_checker.sv
// Concurrent checks on the ports of the transmit beamformer control.
`timescale 1ns/1ps
module tbc_checker
   import tbc_pkg::*;
(
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        chip_disable,
   input wire logic        select_line_pos,
   input wire logic        fire_input,
   input wire logic        serial_output_pin,
   input wire logic        fault_out,
   input wire logic        fault_oe_n,
   input wire logic [15:0] hv_pos,
   input wire logic [15:0] hv_neg,
   input wire logic [15:0] rx_protect_switch
);
   logic [15:0] act;
   assign act = hv_pos | hv_neg;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   rail_excl_a: assert property ((hv_pos & hv_neg) == 16'h0000)
      else $error("channel driven to both rails");
   burst_rx_off_a: assert property ((act & rx_protect_switch) == 16'h0000)
      else $error("receive switch on during burst");
   dis_rx_off_a: assert property (chip_disable [*2] |-> rx_protect_switch == 16'h0000)
      else $error("receive switch on while disabled");
   dis_no_tx_a: assert property (chip_disable [*3] |-> act == 16'h0000)
      else $error("transmit while disabled");
   fire_stop_a: assert property (fire_input [*3] |-> act == 16'h0000)
      else $error("transmit with fire held high");
   select_stop_a: assert property (select_line_pos [*3] |-> act == 16'h0000)
      else $error("transmit during serial frame");
   start_fire_a: assert property ($rose(|act) |-> !$past(fire_input, 2))
      else $error("burst began without fire low");
   sdo_idle_a: assert property (!select_line_pos [*3] |-> !serial_output_pin)
      else $error("serial output active outside frame");
   fault_data_a: assert property (!fault_out)
      else $error("fault data not low");
   addr_err_a: assert property ($fell(rst) |-> ##[1:3] !fault_oe_n)
      else $error("equal addresses not flagged after reset");
endmodule

// file: dv/tbc_host.sv
// Host model that drives the serial link of the beamformer control.
`timescale 1ns/1ps
module tbc_host (
   input  wire logic clk,
   input  wire logic sdo,
   output logic      sel,
   output logic      sclk,
   output logic      sdi,
   output logic      spwr
);
   logic [7:0] tx_q[$];
   logic [7:0] rx_q[$];

   initial begin
      sel = 1'b0;
      sclk = 1'b0;
      sdi = 1'b0;
      spwr = 1'b0;
   end

   // Each serial level lasts two clocks; read data is taken just before the next rise.
   task automatic bitx(input logic b, output logic s);
      @(negedge clk);
      sclk = 1'b0;
      sdi = b;
      repeat (2) @(negedge clk);
      s = sdo;
      sclk = 1'b1;
      @(negedge clk);
   endtask

   task automatic frame(input int nrx);
      logic [7:0] v;
      logic       s;
      if (!spwr) begin
         spwr = 1'b1;
         repeat (7) @(negedge clk);
      end
      @(negedge clk);
      sel = 1'b1;
      rx_q = {};
      foreach (tx_q[k]) begin
         for (int i = 7; i >= 0; i--) bitx(tx_q[k][i], s);
      end
      for (int k = 0; k < nrx; k++) begin
         for (int i = 7; i >= 0; i--) begin
            bitx(~sdi, s);
            v[i] = s;
         end
         rx_q.push_back(v);
      end
      repeat (2) @(negedge clk);
      sel = 1'b0;
      // A released data line must not keep its last level.
      sdi = ~sdi;
      @(negedge clk);
   endtask
endmodule

// file: dv/transmit_beamformer_control_test.sv
// Self-checking bench of the transmit beamformer control.
`timescale 1ns/1ps
module transmit_beamformer_control_test;
   import tbc_pkg::*;
   logic        clk;
   logic        rst;
   logic        chip_disable;
   logic        fire_input;
   logic [7:0]  junction_temp;
   logic        select_line_pos;
   logic        serial_clock;
   logic        serial_input_pin;
   logic        serial_receiver_power;
   logic        serial_output_pin;
   logic        fault_out;
   logic        fault_oe_n;
   logic [15:0] hv_pos;
   logic [15:0] hv_neg;
   logic [15:0] rx_protect_switch;
   int          miscompares;
   int          checks_done;
   logic [7:0]  img[$];
   logic [7:0]  q[$];

   tbc_top dut (.clk(clk), .rst(rst), .chip_disable(chip_disable),
      .select_line_pos(select_line_pos), .serial_clock(serial_clock),
      .serial_input_pin(serial_input_pin), .serial_receiver_power(serial_receiver_power),
      .fire_input(fire_input), .junction_temp(junction_temp),
      .serial_output_pin(serial_output_pin), .fault_out(fault_out), .fault_oe_n(fault_oe_n),
      .hv_pos(hv_pos), .hv_neg(hv_neg), .rx_protect_switch(rx_protect_switch));
   tbc_host host (.clk(clk), .sdo(serial_output_pin), .sel(select_line_pos),
      .sclk(serial_clock), .sdi(serial_input_pin), .spwr(serial_receiver_power));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic results();
      if (miscompares == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   function automatic logic [7:0] crc8(input logic [7:0] d[$]);
      logic [7:0] c;
      c = 8'h00;
      foreach (d[k]) begin
         for (int i = 7; i >= 0; i--) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ d[k][i]) ? 8'h31 : 8'h00);
         end
      end
      return c;
   endfunction

   task automatic rd(input logic [7:0] hdr, input int n);
      host.tx_q = {hdr};
      host.frame(n);
   endtask

   task automatic wr(input logic [7:0] hdr, input logic [7:0] d[$], input logic [7:0] flip);
      host.tx_q = {hdr, d, crc8(d) ^ flip};
      host.frame(0);
   endtask

   task automatic chk1(input logic [7:0] hdr, input logic [7:0] exp);
      rd(hdr, 1);
      check(host.rx_q[0], exp);
   endtask

   task automatic clr_err();
      @(negedge clk);
      chip_disable = 1'b1;
      repeat (2) @(negedge clk);
      chip_disable = 1'b0;
      repeat (2) @(negedge clk);
   endtask

   task automatic test_regs();
      rd(8'h50, 29);
      for (int k = 0; k < 28; k++) check(host.rx_q[k], 8'h00);
      chk1(8'h20, 8'h02);
      check(fault_oe_n, 1'b0);
      // Masks let ch0 and ch1 transmit; ch1 delay is 3, common delay field is 1.
      img = {8'h05, 8'h06, 8'h00, 8'h00, 8'h5a, 8'h00, 8'h03, 8'hff, 8'hff, 8'h01, 8'h00,
             8'h00, 8'hc0};
      while (img.size() < 27) img.push_back(8'h00);
      img.push_back(8'h81);
      wr(8'h40, img, 8'h00);
      rd(8'h50, 29);
      for (int k = 0; k < 28; k++) check(host.rx_q[k], img[k]);
      check(host.rx_q[28], crc8(img));
      chk1(8'h30, crc8(img));
      chk1(8'h20, 8'h02);
      clr_err();
      chk1(8'h20, 8'h00);
      check(fault_oe_n, 1'b1);
   endtask

   task automatic test_badcrc();
      q = img[0:8];
      q[4] = 8'h33;
      wr(8'h00, q, 8'hff);
      chk1(8'h20, 8'h01);
      check(fault_oe_n, 1'b0);
      chk1(8'h30, crc8(q));
      rd(8'h10, 10);
      for (int k = 0; k < 9; k++) check(host.rx_q[k], q[k]);
      check(host.rx_q[9], crc8(q) ^ 8'hff);
      chk1(8'h20, 8'h01);
      img[4] = 8'h33;
      clr_err();
   endtask

   task automatic test_disabled();
      @(negedge clk);
      chip_disable = 1'b1;
      q = {};
      repeat (9) q.push_back(8'hee);
      wr(8'h00, q, 8'h00);
      q = {};
      for (int k = 0; k < 128; k++) q.push_back(k == 5 ? 8'h40 : k == 6 ? 8'h81 : 8'(k * 7));
      wr(8'hc0, q, 8'h00);
      check(rx_protect_switch, 16'h0000);
      rd(8'hd0, 129);
      for (int k = 0; k < 128; k++) check(host.rx_q[k], q[k]);
      check(host.rx_q[128], crc8(q));
      rd(8'h10, 10);
      for (int k = 0; k < 9; k++) check(host.rx_q[k], img[k]);
      @(negedge clk);
      chip_disable = 1'b0;
      repeat (3) @(negedge clk);
      check(rx_protect_switch, 16'hffff);
   endtask

   task automatic fire_run(input logic [7:0] ctl, input logic [7:0] rep, output int t0,
                           output int t1, output int np, output int nn, output int n2);
      q = img[0:8];
      q[2] = ctl;
      q[3] = rep;
      wr(8'h00, q, 8'h00);
      t0 = -1;
      t1 = -1;
      np = 0;
      nn = 0;
      n2 = 0;
      @(negedge clk);
      fire_input = 1'b1;
      @(negedge clk);
      fire_input = 1'b0;
      for (int c = 0; c < 1500; c++) begin
         @(negedge clk);
         if (hv_pos[0] | hv_neg[0] && t0 < 0) t0 = c;
         if (hv_pos[1] | hv_neg[1] && t1 < 0) t1 = c;
         np += hv_pos[0];
         nn += hv_neg[0];
         n2 += hv_pos[2] | hv_neg[2];
      end
   endtask

   task automatic test_fire();
      logic [7:0] ctl[4] = '{8'h00, 8'h44, 8'h88, 8'h4c};
      logic [7:0] rp[4] = '{8'h00, 8'h02, 8'h01, 8'h03};
      int         nd[4] = '{1, 2, 4, 4};
      int         pl[4] = '{1, 2, 16, 3};
      int         t0, t1, np, nn, n2;
      for (int r = 0; r < 4; r++) begin
         fire_run(ctl[r], rp[r], t0, t1, np, nn, n2);
         // Start count plus two cycles: one to set play, one to register the level.
         check(t0, 68 * nd[r] + 4 + 2);
         check(t1 - t0, 3 * nd[r]);
         check(ctl[r][7] ? nn : np, 2 * nd[r] * pl[r]);
         check(ctl[r][7] ? np : nn, 3 * nd[r] * pl[r]);
         check(n2, 0);
      end
      // Over temperature: code 00 blocks transmission, code 11 only reports.
      junction_temp = 8'd140;
      repeat (3) @(negedge clk);
      chk1(8'h20, 8'h04);
      fire_run(8'h00, 8'h00, t0, t1, np, nn, n2);
      check(np + nn, 0);
      fire_run(8'h03, 8'h00, t0, t1, np, nn, n2);
      check(np + nn, 5);
      junction_temp = 8'd25;
      clr_err();
   endtask

   task automatic test_cw();
      q = img[0:8];
      q[3] = 8'hff;
      wr(8'h00, q, 8'h00);
      for (int s = 0; s < 2; s++) begin
         @(negedge clk);
         fire_input = 1'b1;
         @(negedge clk);
         fire_input = 1'b0;
         repeat (400) @(negedge clk);
         check(hv_pos[0] | hv_neg[0], 1'b1);
         if (s == 0) begin
            fire_input = 1'b1;
         end else begin
            chk1(8'h20, 8'h00);
         end
         repeat (3) @(negedge clk);
         check(hv_pos | hv_neg, 16'h0000);
      end
   endtask

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // Whole run needs about 26k cycles; this limit allows well over that.
   initial begin
      #4_000_000;
      miscompares++;
      results();
   end

   initial begin
      rst = 1'b1;
      chip_disable = 1'b0;
      fire_input = 1'b0;
      junction_temp = 8'd25;
      miscompares = 0;
      checks_done = 0;
      repeat (3) @(negedge clk);
      rst = 1'b0;
      test_regs();
      test_badcrc();
      test_disabled();
      test_fire();
      test_cw();
      results();
   end
endmodule

bind tbc_top tbc_checker chk (.clk(clk), .rst(rst), .chip_disable(chip_disable),
   .select_line_pos(select_line_pos), .fire_input(fire_input),
   .serial_output_pin(serial_output_pin), .fault_out(fault_out), .fault_oe_n(fault_oe_n),
   .hv_pos(hv_pos), .hv_neg(hv_neg), .rx_protect_switch(rx_protect_switch));
